/* File: include/pic_line_if.sv */
// Purpose: line hits from detector to core
// Assumes: one bit a line, core clock
// Notes:   level or one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
interface pic_line_if
#(
    parameter int NUM_LINES = 32
);
    logic [NUM_LINES-1:0] hit;
    modport src
    (
        output hit
    );
    modport dst
    (
        input  hit
    );
endinterface
`default_nettype wire

/* File: include/pic_pkg.sv */
// Purpose: shared interrupt controller constants
// Assumes: 32-bit data and address
// Notes:   byte offsets in a 32-byte block
`default_nettype none
package pic_pkg;
    // ****************************************************************
    // bus geometry
    // ****************************************************************
    localparam int          DATA_W     = 32;
    localparam int          ADDR_W     = 32;
    localparam int          BE_W       = DATA_W / 8;
    localparam int          OFFS_W     = 5;
    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [4:0]  OFF_STATUS  = 5'h00;
    localparam logic [4:0]  OFF_PEND    = 5'h04;
    localparam logic [4:0]  OFF_ENABLE  = 5'h08;
    localparam logic [4:0]  OFF_ACK     = 5'h0C;
    localparam logic [4:0]  OFF_SETEN   = 5'h10;
    localparam logic [4:0]  OFF_CLREN   = 5'h14;
    localparam logic [4:0]  OFF_VECTOR  = 5'h18;
    localparam logic [4:0]  OFF_MASTER  = 5'h1C;
    // ****************************************************************
    // fields and reset values
    // ****************************************************************
    localparam int          MASTER_GATE_BIT = 0;
    localparam int          HW_UNLOCK_BIT   = 1;
    localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
    localparam logic [31:0] VECTOR_NONE     = 32'hFFFF_FFFF;
    localparam logic [31:0] DEF_BASE        = 32'h0000_0000;
    localparam logic [31:0] DEF_UPPER       = 32'h0000_001F;
    localparam logic [31:0] DEF_KIND        = 32'hFFFF_FFFF;
    localparam logic [31:0] DEF_POL         = 32'hFFFF_FFFF;
    // ****************************************************************
    // bus answer states
    // ****************************************************************
    typedef enum logic [0:0]
    {
        PIC_BUS_IDLE   = 1'b0,
        PIC_BUS_ANSWER = 1'b1
    } pic_bus_state_t;
endpackage
`default_nettype wire

/* File: src/pic_intc.sv */
// Purpose: interrupt controller, Avalon-MM slave
// Assumes: one clock, async low reset
// Notes:   one wait cycle per access
//
// Behaviour
// - line 0 has top priority.
// - line count is a build parameter, one to bus width.
// - type bit: one edge, zero level.
// - edge bit: one rising, zero falling.
// - level bit: one high, zero low.
// - one request output beside the line vector.
// - form bit: zero pulse, one level.
// - sense bit: one rising or high.
// - pending view built only by its bit.
// - set and clear strobes built by own bits.
// - vector number built only by its bit.
// - unselected features build no logic.
// - bus reset clears the controller.
// - base on 32-byte boundary; slave answers there.
// - window spans at least eight 32-bit words.
// - decoder compares bits above window only.
// - data path width fixed at 32 bits by the package.
// - pending enabled ORed to one gated output.
// - vector reads all ones when none pending.
// - gate one lets output assert, zero blocks.
// - unlock resets zero, write-once enables hardware lines.
`timescale 1ns/100ps
`default_nettype none
module pic_intc
#(
    parameter int          NUM_LINES      = 32,
    parameter logic [31:0] DETECT_TYPE    = pic_pkg::DEF_KIND,
    parameter logic [31:0] EDGE_POLARITY  = pic_pkg::DEF_POL,
    parameter logic [31:0] LEVEL_POLARITY = pic_pkg::DEF_POL,
    parameter bit          REQ_IS_LEVEL   = 1'b1,
    parameter bit          REQ_ACTIVE     = 1'b1,
    parameter bit          BUILD_PEND     = 1'b1,
    parameter bit          BUILD_SET_EN   = 1'b1,
    parameter bit          BUILD_CLR_EN   = 1'b1,
    parameter bit          BUILD_VECTOR   = 1'b1,
    parameter logic [31:0] BASE_ADDRESS   = pic_pkg::DEF_BASE,
    parameter logic [31:0] UPPER_ADDRESS  = pic_pkg::DEF_UPPER
)
(
    input  wire logic                         sys_clk_i,
    input  wire logic                         rst_b_i,
    input  wire logic [NUM_LINES-1:0]         intr_line_i,
    output logic                              irq_o,
    input  wire logic [pic_pkg::ADDR_W-1:0]   avs_address_i,
    input  wire logic                         avs_read_i,
    input  wire logic                         avs_write_i,
    input  wire logic [pic_pkg::DATA_W-1:0]   avs_writedata_i,
    input  wire logic [pic_pkg::BE_W-1:0]     avs_byteenable_i,
    output logic [pic_pkg::DATA_W-1:0]        avs_readdata_o,
    output logic                              avs_waitrequest_o,
    output logic                              slave_transfer_ack_o,
    output logic                              slave_error_ack_o,
    output logic                              slave_retry_o,
    output logic                              slave_timeout_suppress_o
);
    // ****************************************************************
    // local helpers
    // ****************************************************************
    // width from package
    localparam int DW = pic_pkg::DATA_W;

    // merge new data into old under byte lanes
    function automatic logic [DW-1:0] be_merge
    (
        input logic [DW-1:0]            old_v,
        input logic [DW-1:0]            new_v,
        input logic [pic_pkg::BE_W-1:0] be
    );
        logic [DW-1:0] res;
        res = old_v;
        for (int b = 0; b < pic_pkg::BE_W; b++)
        begin
            if (be[b])
            begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // expand byte lanes to a bit mask
    function automatic logic [DW-1:0] be_mask
    (
        input logic [pic_pkg::BE_W-1:0] be
    );
        return be_merge('0, '1, be);
    endfunction

    // lowest set bit index, all ones when none
    function automatic logic [DW-1:0] first_set
    (
        input logic [DW-1:0] v
    );
        logic [DW-1:0] res;
        res = pic_pkg::VECTOR_NONE;
        for (int i = DW - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                res = DW'(i);
            end
        end
        return res;
    endfunction

    // ****************************************************************
    // line detection and output shaping
    // ****************************************************************
    pic_line_if #(.NUM_LINES(NUM_LINES)) line_if ();

    pic_line_detect
    #(
        .NUM_LINES      (NUM_LINES),
        .DETECT_TYPE    (DETECT_TYPE),
        .EDGE_POLARITY  (EDGE_POLARITY),
        .LEVEL_POLARITY (LEVEL_POLARITY)
    )
    u_detect
    (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .lines_i   (intr_line_i),
        .hit_if    (line_if.src)
    );

    logic combined_req;

    pic_irq_shape
    #(
        .REQ_IS_LEVEL (REQ_IS_LEVEL),
        .REQ_ACTIVE   (REQ_ACTIVE)
    )
    u_shape
    (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .req_i     (combined_req),
        .irq_o     (irq_o)
    );

    // ****************************************************************
    // address decode
    // ****************************************************************
    // window from base and upper
    wire [31:0] win_mask_w   = ~(UPPER_ADDRESS - BASE_ADDRESS);
    wire        block_hit_w  = (avs_address_i & win_mask_w)
                               == (BASE_ADDRESS & win_mask_w);
    wire [4:0]  offset_w     = avs_address_i[pic_pkg::OFFS_W-1:0];
    wire        word_align_w = (avs_address_i[1:0] == 2'h0);
    wire        reg_sel_w    = block_hit_w & word_align_w;

    // ****************************************************************
    // bus handshake
    // ****************************************************************
    pic_pkg::pic_bus_state_t state_reg;
    pic_pkg::pic_bus_state_t state_next;

    wire req_w    = avs_read_i | avs_write_i;
    wire answer_w = (state_reg == pic_pkg::PIC_BUS_ANSWER);
    // direction from read and write strobes
    wire wr_do_w  = answer_w & avs_write_i & reg_sel_w;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            pic_pkg::PIC_BUS_IDLE:
            begin
                if (req_w)
                begin
                    state_next = pic_pkg::PIC_BUS_ANSWER;
                end
            end
            pic_pkg::PIC_BUS_ANSWER:
            begin
                state_next = pic_pkg::PIC_BUS_IDLE;
            end
        endcase
    end

    assign avs_waitrequest_o        = req_w & ~answer_w;
    assign slave_transfer_ack_o     = answer_w & req_w;
    assign slave_error_ack_o        = 1'b0;
    assign slave_retry_o            = 1'b0;
    assign slave_timeout_suppress_o = 1'b0;

    // ****************************************************************
    // register file
    // ****************************************************************
    logic [DW-1:0] status_reg;
    logic [DW-1:0] status_next;
    logic [DW-1:0] enable_reg;
    logic [DW-1:0] enable_next;
    logic          gate_reg;
    logic          gate_next;
    logic          unlock_reg;
    logic          unlock_next;
    logic [DW-1:0] rdata_reg;
    logic [DW-1:0] rdata_next;

    wire [DW-1:0] line_mask_w = DW'({NUM_LINES{1'b1}});
    wire [DW-1:0] hw_hit_w    = DW'(line_if.hit);
    wire [DW-1:0] wmask_w     = be_mask(avs_byteenable_i);
    wire [DW-1:0] wbits_w     = avs_writedata_i & wmask_w & line_mask_w;

    wire wr_status_w = wr_do_w & (offset_w == pic_pkg::OFF_STATUS);
    wire wr_enable_w = wr_do_w & (offset_w == pic_pkg::OFF_ENABLE);
    wire wr_ack_w    = wr_do_w & (offset_w == pic_pkg::OFF_ACK);
    wire wr_seten_w  = BUILD_SET_EN & wr_do_w
                       & (offset_w == pic_pkg::OFF_SETEN);
    wire wr_clren_w  = BUILD_CLR_EN & wr_do_w
                       & (offset_w == pic_pkg::OFF_CLREN);
    wire wr_master_w = wr_do_w & (offset_w == pic_pkg::OFF_MASTER)
                       & avs_byteenable_i[0];

    wire [DW-1:0] set_src_w = unlock_reg ? (hw_hit_w & line_mask_w)
                              : (wr_status_w ? wbits_w : '0);
    wire [DW-1:0] clr_src_w = wr_ack_w ? wbits_w : '0;

    // set beats an acknowledge in the same cycle
    assign status_next = (status_reg & ~clr_src_w) | set_src_w;

    // byte lanes gate the enable write
    wire [DW-1:0] en_wr_w = wr_enable_w
                            ? be_merge(enable_reg, avs_writedata_i,
                                       avs_byteenable_i)
                            : enable_reg;
    assign enable_next = ((en_wr_w & ~(wr_clren_w ? wbits_w : '0))
                          | (wr_seten_w ? wbits_w : '0)) & line_mask_w;

    assign gate_next   = wr_master_w
                         ? avs_writedata_i[pic_pkg::MASTER_GATE_BIT]
                         : gate_reg;
    assign unlock_next = unlock_reg
                         | (wr_master_w
                            & avs_writedata_i[pic_pkg::HW_UNLOCK_BIT]);

    // ****************************************************************
    // pending, priority and request
    // ****************************************************************
    wire [DW-1:0] pend_w = status_reg & enable_reg;
    wire [DW-1:0] vec_w  = first_set(pend_w);

    assign combined_req = gate_reg & (|pend_w);

    // ****************************************************************
    // read mux
    // ****************************************************************
    // absent parts fold away
    wire [DW-1:0] rd_pend_w   = BUILD_PEND ? pend_w : '0;
    wire [DW-1:0] rd_vector_w = BUILD_VECTOR ? vec_w
                                : pic_pkg::VECTOR_NONE;
    wire [DW-1:0] rd_master_w = DW'({unlock_reg, gate_reg});

    always_comb
    begin
        rdata_next = '0;
        if (reg_sel_w && avs_read_i && !answer_w)
        begin
            unique case (offset_w)
                pic_pkg::OFF_STATUS: rdata_next = status_reg;
                pic_pkg::OFF_PEND:   rdata_next = rd_pend_w;
                pic_pkg::OFF_ENABLE: rdata_next = enable_reg;
                pic_pkg::OFF_VECTOR: rdata_next = rd_vector_w;
                pic_pkg::OFF_MASTER: rdata_next = rd_master_w;
                default:             rdata_next = '0;
            endcase
        end
        else if (answer_w)
        begin
            rdata_next = rdata_reg;
        end
    end

    assign avs_readdata_o = rdata_reg;

    // ****************************************************************
    // state registers
    // ****************************************************************
    // reset clears all control state
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_reg  <= pic_pkg::PIC_BUS_IDLE;
            status_reg <= pic_pkg::RST_ZERO;
            enable_reg <= pic_pkg::RST_ZERO;
            gate_reg   <= 1'b0;
            unlock_reg <= 1'b0;
            rdata_reg  <= pic_pkg::RST_ZERO;
        end
        else
        begin
            state_reg  <= state_next;
            status_reg <= status_next;
            enable_reg <= enable_next;
            gate_reg   <= gate_next;
            unlock_reg <= unlock_next;
            rdata_reg  <= rdata_next;
        end
    end
endmodule
`default_nettype wire

/* File: src/pic_irq_shape.sv */
// Purpose: shape the request output
// Assumes: req_i synchronous
// Notes:   pulse form lasts one clock
`timescale 1ns/100ps
`default_nettype none
module pic_irq_shape
#(
    parameter bit REQ_IS_LEVEL = 1'b1,
    parameter bit REQ_ACTIVE   = 1'b1
)
(
    input  wire logic sys_clk_i,
    input  wire logic rst_b_i,
    input  wire logic req_i,
    output logic      irq_o
);
    logic req_prev_reg;
    logic irq_reg;
    logic irq_next;
    wire  form_w = REQ_IS_LEVEL ? req_i : (req_i & ~req_prev_reg);

    assign irq_next = REQ_ACTIVE ? form_w : ~form_w;
    assign irq_o    = irq_reg;

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            req_prev_reg <= 1'b0;
            irq_reg      <= ~REQ_ACTIVE;
        end
        else
        begin
            req_prev_reg <= req_i;
            irq_reg      <= irq_next;
        end
    end
endmodule
`default_nettype wire

/* File: src/pic_line_detect.sv */
// Purpose: sync and qualify lines
// Assumes: lines asynchronous
// Notes:   edge hits pulse once
`timescale 1ns/100ps
`default_nettype none
module pic_line_detect
#(
    parameter int          NUM_LINES     = 32,
    parameter logic [31:0] DETECT_TYPE   = pic_pkg::DEF_KIND,
    parameter logic [31:0] EDGE_POLARITY = pic_pkg::DEF_POL,
    parameter logic [31:0] LEVEL_POLARITY = pic_pkg::DEF_POL
)
(
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic [NUM_LINES-1:0] lines_i,
    pic_line_if.src                   hit_if
);
    logic [NUM_LINES-1:0] meta_reg;
    logic [NUM_LINES-1:0] sync_reg;
    logic [NUM_LINES-1:0] prev_reg;

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end
        else
        begin
            meta_reg <= lines_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // ****************************************************************
    // per-line qualification
    // ****************************************************************
    for (genvar i = 0; i < NUM_LINES; i++)
    begin : g_line
        wire rise_w = sync_reg[i] & ~prev_reg[i];
        wire fall_w = ~sync_reg[i] & prev_reg[i];
        wire edge_w = EDGE_POLARITY[i] ? rise_w : fall_w;
        wire lvl_w  = LEVEL_POLARITY[i] ? sync_reg[i] : ~sync_reg[i];
        assign hit_if.hit[i] = DETECT_TYPE[i] ? edge_w : lvl_w;
    end
endmodule
`default_nettype wire

/* File: test/pic_avs_master.sv */
// Purpose: Avalon-MM master model
// Assumes: slave drops waitrequest
// Notes:   idles one edge between transfers
`timescale 1ns/100ps
`default_nettype none
module pic_avs_master
(
    input  wire logic                       sys_clk_i,
    output logic [pic_pkg::ADDR_W-1:0]      address_o,
    output logic                            read_o,
    output logic                            write_o,
    output logic [pic_pkg::DATA_W-1:0]      writedata_o,
    output logic [pic_pkg::BE_W-1:0]        byteenable_o,
    input  wire logic [pic_pkg::DATA_W-1:0] readdata_i,
    input  wire logic                       waitrequest_i
);
    // ****************************************************************
    // transfer
    // ****************************************************************
    initial
    begin
        address_o    = 32'h0;
        read_o       = 1'b0;
        write_o      = 1'b0;
        writedata_o  = 32'h0;
        byteenable_o = 4'h0;
    end
    task automatic xfer(input logic we, input logic [31:0] a, d,
                        input logic [3:0] be, output logic [31:0] q,
                        output logic ok);
        logic w;
        int   n;
        n = 0;
        address_o    <= a;
        writedata_o  <= d;
        byteenable_o <= be;
        read_o       <= !we;
        write_o      <= we;
        // mid-cycle look avoids the edge race
        do
        begin
            @(negedge sys_clk_i);
            w = waitrequest_i;
            @(posedge sys_clk_i);
            n++;
        end
        while (w !== 1'b0 && n < 50);
        q = readdata_i;
        ok = (w === 1'b0);
        read_o  <= 1'b0;
        write_o <= 1'b0;
        @(posedge sys_clk_i);
    endtask
endmodule
`default_nettype wire

/* File: test/pic_intc_props.sv */
// Purpose: bus and request checks
// Assumes: one clock, async low reset
// Notes:   sees top ports only
`timescale 1ns/100ps
`default_nettype none
module pic_intc_props
#(
    parameter int          NUM_LINES     = 32,
    parameter bit          REQ_ACTIVE    = 1'b1,
    parameter logic [31:0] BASE_ADDRESS  = 32'h0000_0000,
    parameter logic [31:0] UPPER_ADDRESS = 32'h0000_001F
)
(
    input  wire logic                       sys_clk_i,
    input  wire logic                       rst_b_i,
    input  wire logic [NUM_LINES-1:0]       intr_line_i,
    input  wire logic                       irq_o,
    input  wire logic [pic_pkg::ADDR_W-1:0] avs_address_i,
    input  wire logic                       avs_read_i,
    input  wire logic                       avs_write_i,
    input  wire logic [pic_pkg::DATA_W-1:0] avs_writedata_i,
    input  wire logic [pic_pkg::BE_W-1:0]   avs_byteenable_i,
    input  wire logic [pic_pkg::DATA_W-1:0] avs_readdata_o,
    input  wire logic                       avs_waitrequest_o,
    input  wire logic                       slave_transfer_ack_o,
    input  wire logic                       slave_error_ack_o,
    input  wire logic                       slave_retry_o,
    input  wire logic                       slave_timeout_suppress_o
);
    // ****************************************************************
    // decode helpers
    // ****************************************************************
    wire logic       req  = avs_read_i | avs_write_i;
    wire logic       done = avs_read_i & ~avs_waitrequest_o;
    wire logic [4:0] offs = avs_address_i[4:0];
    // only bits above the window size take part in the match
    wire logic       hit  = ((avs_address_i ^ BASE_ADDRESS)
                            & ~(UPPER_ADDRESS - BASE_ADDRESS)) == 32'h0;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    wait_once_a: assert property (
        req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("wait too long");
    ack_match_a: assert property (
        slave_transfer_ack_o == (req && !avs_waitrequest_o))
        else $error("ack off answer");
    ack_single_a: assert property (
        slave_transfer_ack_o |=> !slave_transfer_ack_o)
        else $error("ack too long");
    idle_nowait_a: assert property (
        !req |-> !avs_waitrequest_o)
        else $error("idle wait");
    tied_low_a: assert property (
        !(slave_error_ack_o | slave_retry_o | slave_timeout_suppress_o))
        else $error("tied output high");
    irq_reset_a: assert property (
        $rose(rst_b_i) |-> irq_o == !REQ_ACTIVE)
        else $error("irq active at reset");
    miss_zero_a: assert property (
        done && !hit |-> avs_readdata_o == 32'h0)
        else $error("miss not zero");
    vector_range_a: assert property (
        done && hit && offs == pic_pkg::OFF_VECTOR
        |-> avs_readdata_o == pic_pkg::VECTOR_NONE
            || avs_readdata_o < NUM_LINES)
        else $error("vector range");
    master_bits_a: assert property (
        done && hit && offs == pic_pkg::OFF_MASTER
        |-> avs_readdata_o[31:2] == 30'h0)
        else $error("master high bits");
endmodule
bind pic_intc pic_intc_props #(.NUM_LINES(NUM_LINES),
    .REQ_ACTIVE(REQ_ACTIVE), .BASE_ADDRESS(BASE_ADDRESS),
    .UPPER_ADDRESS(UPPER_ADDRESS)) pic_intc_props_i
(
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .intr_line_i(intr_line_i),
    .irq_o(irq_o), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .slave_transfer_ack_o(slave_transfer_ack_o),
    .slave_error_ack_o(slave_error_ack_o), .slave_retry_o(slave_retry_o),
    .slave_timeout_suppress_o(slave_timeout_suppress_o)
);
`default_nettype wire

/* File: test/pic_intc_test.sv */
// Purpose: self-checking controller bench
// Assumes: eight mixed lines, all parts built
// Notes:   fixed-seed random patterns
`timescale 1ns/100ps
`default_nettype none
module pic_intc_test;
    localparam int          NL    = 8;
    localparam logic [31:0] BASE  = 32'h0000_0100;
    localparam logic [31:0] UPPER = 32'h0000_011F;
    logic              sys_clk_i;
    logic              rst_b_i;
    logic [NL-1:0]     lines;
    logic [31:0]       addr, wdata, rdata;
    logic [3:0]        be;
    logic              rd_s, wr_s, wait_s, irq, ack, eack, rty, tsup;
    int                err_total, total_checks;
    logic [15:0]       lfsr_reg;
    logic [7:0]        st, en;
    localparam logic [55:0] LN = 56'h0E_06_07_07_06_04_0A;
    localparam logic [55:0] AK = 56'h00_00_00_0D_01_00_02;
    localparam logic [55:0] EX = 56'h04_0C_0D_01_00_02_00;
    logic [4:0]        ro [5] = '{5'h00, 5'h04, 5'h08, 5'h18, 5'h1C};
    // ****************************************************************
    // instances, clock and helpers
    // ****************************************************************
    // line0/1 level high/low, line2 rising, line3 falling, rest level high
    pic_intc #(.NUM_LINES(NL), .DETECT_TYPE(32'h0000_000C),
        .EDGE_POLARITY(32'h0000_0004), .LEVEL_POLARITY(32'hFFFF_FFFD),
        .BASE_ADDRESS(BASE), .UPPER_ADDRESS(UPPER)) pic_intc_i
    (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .intr_line_i(lines),
        .irq_o(irq), .avs_address_i(addr), .avs_read_i(rd_s),
        .avs_write_i(wr_s), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wait_s), .slave_transfer_ack_o(ack),
        .slave_error_ack_o(eack), .slave_retry_o(rty),
        .slave_timeout_suppress_o(tsup)
    );
    pic_avs_master pic_avs_master_i
    (
        .sys_clk_i(sys_clk_i), .address_o(addr), .read_o(rd_s),
        .write_o(wr_s), .writedata_o(wdata), .byteenable_o(be),
        .readdata_i(rdata), .waitrequest_i(wait_s)
    );
    initial
    begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // lowest pending wins, none is all ones
    function automatic logic [31:0] vec_of(input logic [7:0] p);
        for (int i = 0; i < NL; i++)
            if (p[i])
                return 32'(i);
        return pic_pkg::VECTOR_NONE;
    endfunction
    task automatic check(input string what, input logic [31:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            $display("BAD %s expected %h seen %h", what, e, g);
            err_total++;
        end
    endtask
    task automatic bus(input logic we, input logic [31:0] a, d,
                       input logic [3:0] b, output logic [31:0] q);
        logic ok;
        pic_avs_master_i.xfer(we, a, d, b, q, ok);
        check("bus answer", 32'h1, {31'h0, ok});
    endtask
    task automatic wr(input logic [4:0] o, input logic [31:0] d,
                      input logic [3:0] b = 4'hF);
        logic [31:0] q;
        bus(1'b1, BASE + {27'h0, o}, d, b, q);
    endtask
    task automatic rd(input logic [4:0] o, input logic [31:0] e,
                      input string what);
        logic [31:0] q;
        bus(1'b0, BASE + {27'h0, o}, 32'h0, 4'hF, q);
        check(what, e, q);
    endtask
    task automatic results;
        if (err_total == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        err_total++;
        results();
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        logic [31:0] q;
        err_total = 0;
        total_checks = 0;
        lfsr_reg = 16'hCDF8;
        rst_b_i = 1'b0;
        lines = 8'h0A;
        repeat (4) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        @(posedge sys_clk_i);
        foreach (ro[i])
            rd(ro[i], (ro[i] == 5'h18) ? 32'hFFFF_FFFF : 32'h0, "reset");
        bus(1'b1, 32'h0000_0208, 32'hFF, 4'hF, q);
        bus(1'b0, 32'h0000_0208, 32'h0, 4'hF, q);
        check("unmapped", 32'h0, q);
        rd(pic_pkg::OFF_ENABLE, 32'h0, "enable");
        for (int k = 0; k < 4; k++)
        begin
            lfsr_reg = lfsr_next(lfsr_reg);
            st = lfsr_reg[7:0];
            en = lfsr_reg[15:8];
            wr(pic_pkg::OFF_STATUS, {24'h0, st});
            wr(pic_pkg::OFF_ENABLE, {24'h0, en});
            wr(pic_pkg::OFF_MASTER, 32'h1);
            rd(pic_pkg::OFF_PEND, {24'h0, st & en}, "pending");
            rd(pic_pkg::OFF_VECTOR, vec_of(st & en), "vector");
            check("irq", {31'h0, |(st & en)}, {31'h0, irq});
            wr(pic_pkg::OFF_ACK, 32'hFF);
            rd(pic_pkg::OFF_STATUS, 32'h0, "status");
        end
        wr(pic_pkg::OFF_ENABLE, 32'hFF);
        wr(pic_pkg::OFF_ENABLE, 32'h0, 4'hE);
        rd(pic_pkg::OFF_ENABLE, 32'hFF, "lanes");
        wr(pic_pkg::OFF_STATUS, 32'h1);
        wr(pic_pkg::OFF_MASTER, 32'h0);
        repeat (3) @(posedge sys_clk_i);
        check("irq gated", 32'h0, {31'h0, irq});
        wr(pic_pkg::OFF_MASTER, 32'h1);
        repeat (3) @(posedge sys_clk_i);
        check("irq open", 32'h1, {31'h0, irq});
        wr(pic_pkg::OFF_ACK, 32'hFF);
        wr(pic_pkg::OFF_ENABLE, 32'h0);
        wr(pic_pkg::OFF_SETEN, 32'h5);
        wr(pic_pkg::OFF_CLREN, 32'h1);
        rd(pic_pkg::OFF_ENABLE, 32'h4, "strobes");
        wr(pic_pkg::OFF_MASTER, 32'h3);
        wr(pic_pkg::OFF_MASTER, 32'h1);
        rd(pic_pkg::OFF_MASTER, 32'h3, "unlock");
        wr(pic_pkg::OFF_STATUS, 32'hFF);
        rd(pic_pkg::OFF_STATUS, 32'h0, "sw locked");
        wr(pic_pkg::OFF_ENABLE, 32'hFF);
        for (int i = 6; i >= 0; i--)
        begin
            lines <= LN[i*8 +: 8];
            repeat (5) @(posedge sys_clk_i);
            if (AK[i*8 +: 8] != 8'h0)
                wr(pic_pkg::OFF_ACK, {24'h0, AK[i*8 +: 8]});
            rd(pic_pkg::OFF_STATUS, {24'h0, EX[i*8 +: 8]}, "hw");
        end
        check("irq idle", 32'h0, {31'h0, irq});
        rst_b_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        @(posedge sys_clk_i);
        rd(pic_pkg::OFF_MASTER, 32'h0, "reset again");
        results();
    end
endmodule
`default_nettype wire
